// ==== rtl/scsi_pkg.sv ====
package scsi_pkg;
   // ----------------------------------------------------------------
   // Modes and formats
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SCSI_FMT_STEP_DIR, SCSI_FMT_QUAD, SCSI_FMT_CW_CCW} scsi_fmt_t;
   typedef enum logic [1:0] {SCSI_MODE_POS, SCSI_MODE_SPEED, SCSI_MODE_TORQUE} scsi_mode_t;
   typedef enum logic [1:0] {SCSI_ST_DISABLED, SCSI_ST_RUN} scsi_state_t;

   // ----------------------------------------------------------------
   // Widths and timing
   // ----------------------------------------------------------------
   localparam int          SCSI_POS_W       = 32;
   localparam int          SCSI_ENC_W       = 16;
   localparam int          SCSI_GEAR_W      = 16;
   localparam int          SCSI_ANA_W       = 16;
   localparam int          SCSI_FAULT_N     = 5;
   localparam int          SCSI_CLK_HZ      = 40_000_000;
   localparam int          SCSI_MAX_PULSE_HZ = 500_000;
   localparam int          SCSI_PULSE_CYC   = SCSI_CLK_HZ / SCSI_MAX_PULSE_HZ;
   localparam logic [SCSI_ENC_W-1:0] SCSI_ZERO_ANGLE = 16'h0000;
   localparam logic [SCSI_POS_W-1:0] SCSI_POS_RST    = 32'h0000_0000;
   localparam logic [SCSI_ANA_W-1:0] SCSI_ANA_RST    = 16'h0000;
   localparam logic [1:0]  SCSI_SYNC_RST    = 2'h0;
endpackage

// ==== rtl/scsi_step_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface scsi_step_if;
   logic step;
   logic dir_fwd;
   modport src (output step, output dir_fwd);
   modport dst (input step, input dir_fwd);
endinterface
`default_nettype wire

// ==== rtl/scsi_pulse_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
// Decodes synchronised reference lines into step events: one per edge in quadrature, one per rising edge of A in step/dir, one per lone rising edge in CW/CCW
module scsi_pulse_decode
(
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire logic            flush,
   input  wire scsi_pkg::scsi_fmt_t fmt,
   input  wire logic            line_a,
   input  wire logic            line_b,
   scsi_step_if.src             st
);
   typedef struct packed {
      logic [1:0] sa;
      logic [1:0] sb;
      logic       a_q;
      logic       b_q;
      logic       step_q;
      logic       fwd_q;
   } scsi_dec_t;

   scsi_dec_t s_q, s_d;
   logic      a, b, ra, rb, ea, eb;

   always_comb
   begin
      s_d        = s_q;
      // Second stage only feeds decode logic
      s_d.sa     = {s_q.sa[0], line_a};
      s_d.sb     = {s_q.sb[0], line_b};
      a          = s_q.sa[1];
      b          = s_q.sb[1];
      s_d.a_q    = a;
      s_d.b_q    = b;
      ra         = a & ~s_q.a_q;
      rb         = b & ~s_q.b_q;
      ea         = a ^ s_q.a_q;
      eb         = b ^ s_q.b_q;
      s_d.step_q = 1'b0;
      unique case (fmt)
         scsi_pkg::SCSI_FMT_STEP_DIR:
         begin
            s_d.step_q = ra;
            s_d.fwd_q  = b;
         end
         scsi_pkg::SCSI_FMT_QUAD:
         begin
            // Four counts per cycle; A leading B is forward
            s_d.step_q = ea | eb;
            s_d.fwd_q  = ea ? (a ^ b) : ~(a ^ b);
         end
         scsi_pkg::SCSI_FMT_CW_CCW:
         begin
            s_d.step_q = ra ^ rb;
            s_d.fwd_q  = ra;
         end
         default:
         begin
            s_d.step_q = 1'b0;
         end
      endcase
      if (flush)
         s_d.step_q = 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign st.step    = s_q.step_q;
   assign st.dir_fwd = s_q.fwd_q;

   step_gap_a: assert property (@(posedge mclk) disable iff (rst)
      s_q.step_q |=> !s_q.step_q || fmt == scsi_pkg::SCSI_FMT_QUAD)
      else $error("step pulse longer than one cycle");
endmodule
`default_nettype wire

// ==== rtl/scsi_servo_io.sv ====
`timescale 1ns/1ps
`default_nettype none
module scsi_servo_io
#(
   parameter int POS_W  = scsi_pkg::SCSI_POS_W,
   parameter int ENC_W  = scsi_pkg::SCSI_ENC_W,
   parameter int GEAR_W = scsi_pkg::SCSI_GEAR_W,
   parameter int ANA_W  = scsi_pkg::SCSI_ANA_W
)
(
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       drive_disable_in,
   input  wire logic                       forward_pulse_line,
   input  wire logic                       reverse_pulse_line,
   input  wire scsi_pkg::scsi_fmt_t        pulse_format,
   input  wire scsi_pkg::scsi_mode_t       servo_mode,
   input  wire logic [GEAR_W-1:0]          gear_ratio_setting,
   input  wire logic [POS_W-1:0]           in_position_window,
   input  wire logic signed [ANA_W-1:0]    analog_cmd_in,
   input  wire logic [ENC_W-1:0]           encoder_angle,
   input  wire logic signed [POS_W-1:0]    actual_position,
   input  wire logic [scsi_pkg::SCSI_FAULT_N-1:0] fault_sources,
   output logic                            phase_drive_en,
   output logic signed [POS_W-1:0]         position_cmd,
   output logic signed [POS_W-1:0]         position_error,
   output logic signed [ANA_W-1:0]         analog_ref,
   output logic                            analog_ref_valid,
   output logic                            zero_index_out,
   output logic                            zero_index_oe,
   output logic                            in_position_out,
   output logic                            in_position_oe,
   output logic                            fault_out,
   output logic                            fault_oe
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]                   dis_sync;
      scsi_pkg::scsi_state_t        st;
      logic signed [POS_W-1:0]      cmd;
      logic signed [POS_W-1:0]      err;
      logic signed [ANA_W-1:0]      ana;
      logic                         ana_v;
      logic                         zero;
      logic                         inpos;
      logic                         fault;
   } scsi_top_t;

   scsi_top_t   s_q, s_d;
   scsi_step_if stp ();
   logic        disabled;
   logic [POS_W-1:0] err_abs;
   logic signed [POS_W-1:0] gear_step;

   scsi_pulse_decode u_dec
   (
      .mclk   (mclk),
      .rst    (rst),
      .flush  (disabled),
      .fmt    (pulse_format),
      .line_a (forward_pulse_line),
      .line_b (reverse_pulse_line),
      .st     (stp)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d          = s_q;
      s_d.dis_sync = {s_q.dis_sync[0], drive_disable_in};
      disabled     = s_q.dis_sync[1];
      gear_step    = POS_W'(signed'({1'b0, gear_ratio_setting}));
      err_abs      = s_q.err[POS_W-1] ? POS_W'(-s_q.err) : POS_W'(s_q.err);
      unique case (s_q.st)
         scsi_pkg::SCSI_ST_DISABLED:
         begin
            // Command tracks the shaft so enabling does not lurch
            s_d.cmd   = actual_position;
            s_d.err   = scsi_pkg::SCSI_POS_RST;
            s_d.ana   = scsi_pkg::SCSI_ANA_RST;
            s_d.ana_v = 1'b0;
            if (!disabled)
               s_d.st = scsi_pkg::SCSI_ST_RUN;
         end
         scsi_pkg::SCSI_ST_RUN:
         begin
            if (servo_mode == scsi_pkg::SCSI_MODE_POS && stp.step)
               s_d.cmd = stp.dir_fwd ? s_q.cmd + gear_step : s_q.cmd - gear_step;
            s_d.err   = s_d.cmd - actual_position;
            s_d.ana_v = servo_mode != scsi_pkg::SCSI_MODE_POS;
            s_d.ana   = s_d.ana_v ? analog_cmd_in : scsi_pkg::SCSI_ANA_RST;
            if (disabled)
            begin
               s_d.st    = scsi_pkg::SCSI_ST_DISABLED;
               s_d.err   = scsi_pkg::SCSI_POS_RST;
               s_d.ana   = scsi_pkg::SCSI_ANA_RST;
               s_d.ana_v = 1'b0;
            end
         end
      endcase
      s_d.zero  = encoder_angle == scsi_pkg::SCSI_ZERO_ANGLE;
      s_d.inpos = err_abs <= in_position_window;
      s_d.fault = |fault_sources;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q          <= '0;
         s_q.dis_sync <= scsi_pkg::SCSI_SYNC_RST;
         s_q.st       <= scsi_pkg::SCSI_ST_DISABLED;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // Outputs; open collector pulls low when enable is high
   // ----------------------------------------------------------------
   assign phase_drive_en   = s_q.st == scsi_pkg::SCSI_ST_RUN && !disabled;
   assign position_cmd     = s_q.cmd;
   assign position_error   = s_q.err;
   assign analog_ref       = s_q.ana;
   assign analog_ref_valid = s_q.ana_v;
   assign zero_index_out   = 1'b0;
   assign zero_index_oe    = s_q.zero;
   assign in_position_out  = 1'b0;
   assign in_position_oe   = !s_q.inpos;
   assign fault_out        = 1'b0;
   assign fault_oe         = s_q.fault;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   coast_on_disable_a: assert property (@(posedge mclk) disable iff (rst)
      s_q.dis_sync[1] |-> !phase_drive_en) else $error("drive on while disabled");
   err_cleared_a: assert property (@(posedge mclk) disable iff (rst)
      s_q.dis_sync[1] |=> position_error == '0) else $error("error kept");
   analog_flush_a: assert property (@(posedge mclk) disable iff (rst)
      s_q.dis_sync[1] |=> !analog_ref_valid && analog_ref == '0) else $error("analog kept");
   sync_delay_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(drive_disable_in) ##1 drive_disable_in |=> s_q.dis_sync[1]) else $error("sync");
   zero_index_a: assert property (@(posedge mclk) disable iff (rst)
      encoder_angle == scsi_pkg::SCSI_ZERO_ANGLE |=> zero_index_oe) else $error("index");
   inpos_a: assert property (@(posedge mclk) disable iff (rst)
      err_abs > in_position_window |=> in_position_oe) else $error("in position");
   fault_low_a: assert property (@(posedge mclk) disable iff (rst)
      fault_sources != '0 |=> fault_oe) else $error("fault not shown");
   pos_mode_analog_a: assert property (@(posedge mclk) disable iff (rst)
      servo_mode == scsi_pkg::SCSI_MODE_POS |=> !analog_ref_valid) else $error("analog");

   // ----------------------------------------------------------------
   // Step and disable sequences
   // ----------------------------------------------------------------
   sequence seq_pos_step;
      s_q.st == scsi_pkg::SCSI_ST_RUN && servo_mode == scsi_pkg::SCSI_MODE_POS && stp.step;
   endsequence

   sequence seq_run_idle;
      s_q.st == scsi_pkg::SCSI_ST_RUN && !disabled;
   endsequence

   sequence seq_disable_seen;
      s_q.st == scsi_pkg::SCSI_ST_RUN && disabled;
   endsequence

   sequence seq_enable_seen;
      s_q.st == scsi_pkg::SCSI_ST_DISABLED && !disabled;
   endsequence

   // ----------------------------------------------------------------
   // Command, error and state checks
   // ----------------------------------------------------------------
   fwd_step_add_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_pos_step ##0 stp.dir_fwd
      |=> position_cmd == $past(position_cmd) + $past(gear_step))
      else $error("forward step not added");

   rev_step_sub_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_pos_step ##0 !stp.dir_fwd
      |=> position_cmd == $past(position_cmd) - $past(gear_step))
      else $error("reverse step not subtracted");

   cmd_hold_a: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == scsi_pkg::SCSI_ST_RUN && !(stp.step && servo_mode == scsi_pkg::SCSI_MODE_POS)
      |=> position_cmd == $past(position_cmd))
      else $error("command moved without a step");

   cmd_tracks_a: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == scsi_pkg::SCSI_ST_DISABLED
      |=> position_cmd == $past(actual_position))
      else $error("command not tracking shaft");

   err_follows_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_run_idle
      |=> position_error == position_cmd - $past(actual_position))
      else $error("error not command minus actual");

   disable_exit_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_disable_seen
      |=> s_q.st == scsi_pkg::SCSI_ST_DISABLED)
      else $error("run kept while disabled");

   enable_entry_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_enable_seen
      |=> s_q.st == scsi_pkg::SCSI_ST_RUN)
      else $error("run not entered on enable");

   drive_on_run_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_run_idle
      |-> phase_drive_en)
      else $error("drive off while running");

   run_keeps_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_run_idle
      |=> s_q.st == scsi_pkg::SCSI_ST_RUN)
      else $error("run left while enabled");

   dis_keeps_a: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == scsi_pkg::SCSI_ST_DISABLED && disabled
      |=> s_q.st == scsi_pkg::SCSI_ST_DISABLED && !phase_drive_en)
      else $error("disabled state left early");

   disable_flush_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_disable_seen
      |=> (position_error == '0 && !analog_ref_valid)
      ##1 (position_cmd == $past(actual_position)))
      else $error("disable did not flush");

   flush_no_step_a: assert property (
      @(posedge mclk) disable iff (rst)
      disabled
      |=> !stp.step)
      else $error("step passed while disabled");

   dis_no_analog_a: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == scsi_pkg::SCSI_ST_DISABLED
      |=> !analog_ref_valid)
      else $error("analog valid while disabled");

   dis_err_zero_a: assert property (
      @(posedge mclk) disable iff (rst)
      s_q.st == scsi_pkg::SCSI_ST_DISABLED
      |=> position_error == '0)
      else $error("error kept while disabled");

   speed_analog_a: assert property (
      @(posedge mclk) disable iff (rst)
      seq_run_idle ##0 servo_mode != scsi_pkg::SCSI_MODE_POS
      |=> analog_ref_valid && analog_ref == $past(analog_cmd_in))
      else $error("analog not passed on");

   ana_pos_zero_a: assert property (
      @(posedge mclk) disable iff (rst)
      servo_mode == scsi_pkg::SCSI_MODE_POS
      |=> analog_ref == '0)
      else $error("analog kept in position mode");

   inpos_release_a: assert property (
      @(posedge mclk) disable iff (rst)
      err_abs <= in_position_window
      |=> !in_position_oe)
      else $error("in position not released");

   zero_release_a: assert property (
      @(posedge mclk) disable iff (rst)
      encoder_angle != scsi_pkg::SCSI_ZERO_ANGLE
      |=> !zero_index_oe)
      else $error("index away from zero");

   fault_clear_a: assert property (
      @(posedge mclk) disable iff (rst)
      fault_sources == '0
      |=> !fault_oe)
      else $error("fault shown without source");
endmodule
`default_nettype wire

// ==== testbench/scsi_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Controller side: reference lines, zero index capture
// ----------------------------------------------------------------
module scsi_ctl_model
#(
   parameter int GAP  = scsi_pkg::SCSI_PULSE_CYC,
   parameter int WAKE = 60
)
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic zero_pin,
   output logic      line_a,
   output logic      line_b,
   output int        zero_seen
);
   logic zero_q;
   int   awake;

   initial
   begin
      line_a = 1'b0;
      line_b = 1'b0;
   end

   // Only the falling edge counts; level is ignored
   always @(posedge mclk)
   begin
      zero_q <= rst ? 1'b1 : zero_pin;
      zero_seen <= rst ? 0 : zero_seen + int'(zero_q && !zero_pin);
      awake <= rst ? 0 : awake + 1;
   end

   task automatic gap();
      repeat (GAP) @(posedge mclk);
   endtask

   task automatic send(input scsi_pkg::scsi_fmt_t fmt, input logic fwd);
      // Scaled power-on quiet time, no earlier edge
      while (awake < WAKE)
         @(posedge mclk);
      case (fmt)
         scsi_pkg::SCSI_FMT_STEP_DIR:
         begin
            line_b <= fwd;
            gap();
            line_a <= 1'b1;
            gap();
            line_a <= 1'b0;
         end
         scsi_pkg::SCSI_FMT_QUAD:
            if ((line_a == line_b) == fwd)
               line_a <= !line_a;
            else
               line_b <= !line_b;
         default:
         begin
            if (fwd)
               line_a <= 1'b1;
            else
               line_b <= 1'b1;
            gap();
            line_a <= 1'b0;
            line_b <= 1'b0;
         end
      endcase
      gap();
   endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {scsi_pkg::scsi_fmt_t f; logic fw; logic [15:0] g; logic [31:0] d;} scsi_row_t;
   scsi_row_t rows [6] = '{
      '{scsi_pkg::SCSI_FMT_STEP_DIR, 1'b1, 16'h0001, 32'h0000_0001},
      '{scsi_pkg::SCSI_FMT_STEP_DIR, 1'b0, 16'h0003, 32'hffff_fffd},
      '{scsi_pkg::SCSI_FMT_QUAD,     1'b1, 16'h0100, 32'h0000_0100},
      '{scsi_pkg::SCSI_FMT_QUAD,     1'b0, 16'h0002, 32'hffff_fffe},
      '{scsi_pkg::SCSI_FMT_CW_CCW,   1'b1, 16'hffff, 32'h0000_ffff},
      '{scsi_pkg::SCSI_FMT_CW_CCW,   1'b0, 16'h0005, 32'hffff_fffb}};
   logic mclk, rst, dis, la, lb, pen, av, zo, zoe, io, ioe, fo, foe;
   scsi_pkg::scsi_fmt_t  fmt;
   scsi_pkg::scsi_mode_t mode;
   logic [15:0] gear, ang, ana, aref;
   logic [31:0] win, act, cmd, err, exp_cmd;
   logic [4:0]  flt;
   int          zs, cycles, compares, miscompares;

   scsi_servo_io u_dut (.mclk(mclk), .rst(rst), .drive_disable_in(dis), .forward_pulse_line(la),
      .reverse_pulse_line(lb), .pulse_format(fmt), .servo_mode(mode), .gear_ratio_setting(gear),
      .in_position_window(win), .analog_cmd_in(ana), .encoder_angle(ang), .actual_position(act),
      .fault_sources(flt), .phase_drive_en(pen), .position_cmd(cmd), .position_error(err),
      .analog_ref(aref), .analog_ref_valid(av), .zero_index_out(zo), .zero_index_oe(zoe),
      .in_position_out(io), .in_position_oe(ioe), .fault_out(fo), .fault_oe(foe));
   scsi_ctl_model u_ctl (.mclk(mclk), .rst(rst), .zero_pin(zoe ? zo : 1'b1), .line_a(la),
      .line_b(lb), .zero_seen(zs));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Ceiling well above the roughly 1400 cycles the run needs
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   initial
   begin
      rst = 1'b1;
      dis = 1'b0;
      fmt = scsi_pkg::SCSI_FMT_STEP_DIR;
      mode = scsi_pkg::SCSI_MODE_POS;
      gear = 16'h0000;
      win = 32'h0000_0000;
      ana = 16'h0000;
      act = 32'h0000_0000;
      flt = 5'h00;
      ang = 16'h0001;
      tick(2);
      chk(32'(foe), 32'h0);
      chk(cmd, 32'h0);
      @(posedge mclk);
      rst <= 1'b0;
      exp_cmd = 32'h0;
      foreach (rows[i])
      begin
         @(posedge mclk);
         fmt <= rows[i].f;
         gear <= rows[i].g;
         u_ctl.send(rows[i].f, rows[i].fw);
         exp_cmd = exp_cmd + rows[i].d;
         #1;
         chk(cmd, exp_cmd);
         $display("row %0d done", i);
      end
      chk(err, exp_cmd);
      win <= exp_cmd;
      tick(4);
      chk(32'(ioe), 32'h0);
      win <= exp_cmd - 32'h1;
      tick(4);
      chk(32'(ioe), 32'h1);
      $display("in-position test done");
      mode <= scsi_pkg::SCSI_MODE_SPEED;
      ana <= 16'h1234;
      u_ctl.send(scsi_pkg::SCSI_FMT_CW_CCW, 1'b1);
      #1;
      chk(cmd, exp_cmd);
      chk({aref, 15'h0, av}, 32'h1234_0001);
      mode <= scsi_pkg::SCSI_MODE_TORQUE;
      ana <= 16'hedcb;
      tick(4);
      chk({aref, 15'h0, av}, 32'hedcb_0001);
      mode <= scsi_pkg::SCSI_MODE_POS;
      tick(4);
      chk(32'(av), 32'h0);
      $display("analog test done");
      foreach (rows[k])
      begin
         ang <= (k % 2) ? 16'h0000 : 16'h8000 + 16'(k * 16'h3fff);
         tick(4);
         chk({31'h0, zoe} + 32'(zs), 32'((k + 1) / 2 + k % 2));
      end
      $display("zero index test done");
      for (int k = 0; k < 6; k++)
      begin
         flt <= (k < 5) ? 5'(1 << k) : 5'h00;
         tick(4);
         chk(32'(foe), 32'(k < 5));
      end
      $display("fault test done");
      act <= 32'h0000_0040;
      fork
         u_ctl.send(scsi_pkg::SCSI_FMT_CW_CCW, 1'b1);
         begin
            tick(1);
            @(posedge mclk);
            dis <= 1'b1;
         end
      join
      #1;
      chk(32'(pen), 32'h0);
      chk(err, 32'h0);
      chk(cmd, 32'h0000_0040);
      dis <= 1'b0;
      tick(6);
      chk(32'(pen), 32'h1);
      chk(cmd, 32'h0000_0040);
      $display("disable test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
